// [hw/lbo_alu.sv]
/*
  Combinational add / and unit with carry, nibble carry and zero outputs.
  Assumes the caller registers every result it keeps.
*/
`timescale 1ns/1ps
module lbo_alu #(
  parameter int DATA_W = 8
) (
  lbo_alu_if.alu port
);
  import lbo_pkg::*;

  logic [DATA_W:0] sum;
  logic [NIBBLE_TOP+1:0] low_sum;

  // nibble carry needs at least one full nibble below the top
  if (DATA_W < NIBBLE_TOP + 2) begin : g_bad_width
    $error("lbo_alu: DATA_W too small for nibble carry");
  end

  // carry out of the top bit and of bit 3
  assign sum = {1'b0, port.a} + {1'b0, port.b};
  assign low_sum = {1'b0, port.a[NIBBLE_TOP:0]} + {1'b0, port.b[NIBBLE_TOP:0]};

  // result select and flags
  assign port.result = port.do_add ? sum[DATA_W-1:0] : (port.a & port.b);
  assign port.carry = sum[DATA_W];
  assign port.nibble_carry = low_sum[NIBBLE_TOP+1];
  assign port.zero = (port.result == '0);

endmodule : lbo_alu

// [hw/lbo_alu_if.sv]
/*
  Carrier between the datapath and its arithmetic/logic unit.
  Assumes the unit is purely combinational.
*/
`timescale 1ns/1ps
interface lbo_alu_if #(
  parameter int DATA_W = 8
);
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic do_add;
  logic [DATA_W-1:0] result;
  logic carry;
  logic nibble_carry;
  logic zero;

  modport core (output a, output b, output do_add, input result, input carry, input nibble_carry, input zero);
  modport alu (input a, input b, input do_add, output result, output carry, output nibble_carry, output zero);
endinterface : lbo_alu_if

// [hw/lbo_datapath.sv]
/*
  Execution datapath for literal add/and, register add/and, bit set/clear,
  skip-if-bit-one and register clear, with accumulator and status flags.
  Assumes the core presents one instruction per issue pulse, with file read
  data and pin levels valid combinationally in that same cycle, and that the
  core writes file_wr_data to file_wr_addr when file_wr_en is high.
*/
// Notes on behaviour
// - literal add updates accumulator, carry, nibble, zero
// - literal and updates accumulator and zero only
// - register and to chosen destination, zero only
// - register add to chosen destination, all flags
// - bit clear changes one bit, no flags
// - bit set changes one bit, no flags
// - tested bit one discards next instruction
// - tested bit zero continues, flags untouched
// - register clear writes zero, sets zero flag
// - port read-modify-write uses pin levels
// - successful test makes second cycle a nop
`timescale 1ns/1ps
module lbo_datapath #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7,
  parameter int BIT_W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic issue,
  input wire lbo_pkg::lbo_op_t op,
  input wire logic [DATA_W-1:0] literal,
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic dest,
  input wire logic [BIT_W-1:0] bit_sel,
  input wire logic [DATA_W-1:0] file_rd_data,
  input wire logic file_is_port,
  input wire logic [DATA_W-1:0] pin_level,
  output logic [DATA_W-1:0] acc,
  output logic carry_flag,
  output logic nibble_overflow_flag,
  output logic zero_flag,
  output logic file_wr_en,
  output logic [ADDR_W-1:0] file_wr_addr,
  output logic [DATA_W-1:0] file_wr_data,
  output logic slot_discarded
);
  import lbo_pkg::*;

  // the bit index must span exactly the data width
  if (DATA_W != (1 << BIT_W) || DATA_W != lbo_pkg::DATA_W || ADDR_W < 1) begin : g_bad_params
    $error("lbo_datapath: unsupported width parameters");
  end

  logic skip_pending;
  logic exec;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] bit_mask;
  logic is_add;
  logic is_imm;
  logic test_bit;

  lbo_alu_if #(.DATA_W(DATA_W)) alu_bus ();

  lbo_alu #(.DATA_W(DATA_W)) u_alu (
    .port(alu_bus)
  );

  // an issue slot behind a taken skip is swallowed, never executed
  assign exec = issue && !skip_pending;

  // pins not latch
  // pins are read for ports so an externally pulled input is written back as seen
  assign operand = file_is_port ? pin_level : file_rd_data;

  // operand and mode decode
  assign bit_mask = DATA_W'(1) << bit_sel;
  assign is_add = (op == add_immediate_op) || (op == add_register_op);
  assign is_imm = (op == add_immediate_op) || (op == and_immediate_op);
  assign test_bit = operand[bit_sel];

  // alu feed: accumulator against literal or file operand
  assign alu_bus.a = acc;
  assign alu_bus.b = is_imm ? literal : operand;
  assign alu_bus.do_add = is_add;

  // accumulator update
  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= ACC_RESET;
    end else if (exec) begin
      unique case (op)
        add_immediate_op, and_immediate_op: begin
          acc <= alu_bus.result;
        end
        add_register_op, and_register_op: begin
          if (dest == DEST_ACC) begin
            acc <= alu_bus.result;
          end
        end
        bit_clear_op, bit_set_op, skip_if_bit_one_op, register_zero_op: begin
          acc <= acc;
        end
      endcase
    end
  end

  // status flags; bit and skip operations leave them alone
  always_ff @(posedge clk) begin
    if (rst) begin
      carry_flag <= FLAG_RESET;
      nibble_overflow_flag <= FLAG_RESET;
      zero_flag <= FLAG_RESET;
    end else if (exec) begin
      unique case (op)
        add_immediate_op, add_register_op: begin
          carry_flag <= alu_bus.carry;
          nibble_overflow_flag <= alu_bus.nibble_carry;
          zero_flag <= alu_bus.zero;
        end
        and_immediate_op, and_register_op: begin
          zero_flag <= alu_bus.zero;
        end
        register_zero_op: begin
          zero_flag <= 1'b1;
        end
        bit_clear_op, bit_set_op, skip_if_bit_one_op: begin
          zero_flag <= zero_flag;
        end
      endcase
    end
  end

  // file write-back port
  always_ff @(posedge clk) begin
    if (rst) begin
      file_wr_en <= 1'b0;
      file_wr_addr <= '0;
      file_wr_data <= ZERO_BYTE;
    end else begin
      file_wr_en <= 1'b0;
      if (exec) begin
        file_wr_addr <= file_addr;
        unique case (op)
          add_register_op, and_register_op: begin
            file_wr_en <= (dest == DEST_FILE);
            file_wr_data <= alu_bus.result;
          end
          bit_clear_op: begin
            file_wr_en <= 1'b1;
            file_wr_data <= operand & ~bit_mask;
          end
          bit_set_op: begin
            file_wr_en <= 1'b1;
            file_wr_data <= operand | bit_mask;
          end
          register_zero_op: begin
            file_wr_en <= 1'b1;
            file_wr_data <= ZERO_BYTE;
          end
          add_immediate_op, and_immediate_op, skip_if_bit_one_op: begin
            file_wr_en <= 1'b0;
          end
        endcase
      end
    end
  end

  // skip tracking; the pending flag holds until the next slot arrives
  always_ff @(posedge clk) begin
    if (rst) begin
      skip_pending <= 1'b0;
      slot_discarded <= 1'b0;
    end else begin
      slot_discarded <= issue && skip_pending;
      if (issue && skip_pending) begin
        skip_pending <= 1'b0;
      end else if (exec && op == skip_if_bit_one_op) begin
        skip_pending <= test_bit;
      end
    end
  end

  // checking helpers
  logic [DATA_W:0] chk_sum;
  logic [NIBBLE_TOP+1:0] chk_low;
  assign chk_sum = {1'b0, acc} + {1'b0, (is_imm ? literal : operand)};
  assign chk_low = {1'b0, acc[NIBBLE_TOP:0]} + {1'b0, (is_imm ? literal[NIBBLE_TOP:0] : operand[NIBBLE_TOP:0])};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_imm_add_acc: assert property (
    exec && op == add_immediate_op |=> acc == DATA_W'($past(acc) + $past(literal)))
    else $error("literal add result wrong");
  a_imm_and_acc: assert property (
    exec && op == and_immediate_op |=> acc == ($past(acc) & $past(literal)) && $stable(carry_flag)
      && zero_flag == (acc == '0))
    else $error("literal and result wrong");
  a_reg_and_dest: assert property (
    exec && op == and_register_op && dest == DEST_FILE |=> file_wr_en && $stable(acc)
      && file_wr_data == ($past(acc) & $past(operand)) && file_wr_addr == $past(file_addr))
    else $error("register and to file wrong");
  a_reg_add_acc: assert property (
    exec && op == add_register_op && dest == DEST_ACC |=> !file_wr_en
      && acc == $past(chk_sum[DATA_W-1:0]) && carry_flag == $past(chk_sum[DATA_W]))
    else $error("register add to accumulator wrong");
  a_bit_clear_one: assert property (
    exec && op == bit_clear_op |=> file_wr_en && file_wr_data == ($past(operand) & ~$past(bit_mask))
      && $stable({carry_flag, nibble_overflow_flag, zero_flag}))
    else $error("bit clear wrong");
  a_bit_set_one: assert property (
    exec && op == bit_set_op |=> file_wr_en && file_wr_data == ($past(operand) | $past(bit_mask)) && $stable(acc))
    else $error("bit set wrong");
  a_skip_taken_nop: assert property (
    (exec && op == skip_if_bit_one_op && test_bit) ##1 issue |=> slot_discarded && !file_wr_en
      && $stable({acc, carry_flag, nibble_overflow_flag, zero_flag}))
    else $error("taken skip did not discard next slot");
  a_skip_not_taken: assert property (
    (exec && op == skip_if_bit_one_op && !test_bit) ##1 issue |=> !slot_discarded)
    else $error("untaken skip discarded a slot");
  a_skip_flags_kept: assert property (
    exec && op == skip_if_bit_one_op |=> $stable({carry_flag, nibble_overflow_flag, zero_flag})
      && !file_wr_en && $stable(acc))
    else $error("skip test altered state");
  a_clear_sets_zero: assert property (
    exec && op == register_zero_op |=> zero_flag && file_wr_en && file_wr_data == ZERO_BYTE)
    else $error("register clear wrong");
  a_port_pin_read: assert property (
    exec && file_is_port && op == bit_set_op |=> file_wr_data == ($past(pin_level) | $past(bit_mask)))
    else $error("port write-back not from pins");
  a_nibble_flag_add: assert property (
    exec && is_add |=> nibble_overflow_flag == $past(chk_low[NIBBLE_TOP+1]))
    else $error("nibble overflow flag wrong");

  c_skip_taken: cover property (exec && op == skip_if_bit_one_op && test_bit ##1 issue ##1 slot_discarded);
  c_add_carry: cover property (exec && is_add ##1 carry_flag && zero_flag);
  c_port_clear: cover property (exec && file_is_port && op == bit_clear_op);

endmodule : lbo_datapath

// [hw/lbo_pkg.sv]
/*
  Shared constants and types for the literal and bit-operation datapath.
  Assumes a single 8-bit data path and 7-bit direct file addressing.
*/
package lbo_pkg;

  // widths of the instruction fields
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;

  // carry out of this bit feeds the nibble overflow flag
  localparam int NIBBLE_TOP = 3;

  // destination select encoding
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // a taken skip makes the test occupy this many instruction cycles
  localparam int SKIP_CYCLES = 2;

  // operations carried out by this datapath
  typedef enum logic [2:0] {
    add_immediate_op = 3'h0,
    and_immediate_op = 3'h1,
    and_register_op = 3'h2,
    add_register_op = 3'h3,
    bit_clear_op = 3'h4,
    bit_set_op = 3'h5,
    skip_if_bit_one_op = 3'h6,
    register_zero_op = 3'h7
  } lbo_op_t;

endpackage : lbo_pkg

// [verification/tb_lbo_datapath.sv]
/*
  Self-checking bench for the literal and bit-operation datapath.
  Assumes the bench plays the core: it issues slots and serves file reads.
*/
`timescale 1ns/1ps
module tb_lbo_datapath;
  import lbo_pkg::*;
  logic clk, rst, issue, dest, file_is_port, carry_flag, nibble_overflow_flag, zero_flag, file_wr_en, slot_discarded;
  lbo_op_t op;
  logic [7:0] literal, file_rd_data, pin_level, acc, file_wr_data;
  logic [6:0] file_addr, file_wr_addr;
  logic [2:0] bit_sel, flg, keep;
  int n_fail = 0;
  int check_count = 0;

  // flags seen as carry, nibble, zero
  assign flg = {carry_flag, nibble_overflow_flag, zero_flag};

  lbo_datapath i_dut (.clk(clk), .rst(rst), .issue(issue), .op(op), .literal(literal), .file_addr(file_addr),
    .dest(dest), .bit_sel(bit_sel), .file_rd_data(file_rd_data), .file_is_port(file_is_port),
    .pin_level(pin_level), .acc(acc), .carry_flag(carry_flag), .nibble_overflow_flag(nibble_overflow_flag),
    .zero_flag(zero_flag), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .slot_discarded(slot_discarded));

  // 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // compare tasks, one per kind of result
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_flags(input logic [2:0] got, input logic [2:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: flags %h expected %h", $time, got, exp);
    end
  endtask : chk_flags

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: bit %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  // one slot; issue stays high so calls run back to back, results read at the next falling edge
  task automatic run(input lbo_op_t o, input logic [7:0] k, input logic [7:0] rd, input logic d = 1'b0,
    input logic [2:0] b = 3'h0, input logic p = 1'b0, input logic [7:0] pin = 8'h00);
    issue = 1'b1;
    op = o;
    literal = k;
    file_addr = k[6:0] ^ 7'h7f;
    file_rd_data = rd;
    dest = d;
    bit_sel = b;
    file_is_port = p;
    pin_level = pin;
    @(negedge clk);
  endtask : run

  task automatic idle();
    issue = 1'b0;
    @(negedge clk);
  endtask : idle

  task automatic t_literal();
    chk_byte(acc, ACC_RESET);
    chk_flags(flg, {FLAG_RESET, FLAG_RESET, FLAG_RESET});
    chk_bit(file_wr_en, 1'b0);
    chk_bit(slot_discarded, 1'b0);
    run(add_immediate_op, 8'hff, 8'h00);
    chk_byte(acc, 8'hff);
    chk_flags(flg, 3'b000);
    run(add_immediate_op, 8'h01, 8'h00);
    chk_byte(acc, 8'h00);
    chk_flags(flg, 3'b111);
    run(add_immediate_op, 8'h08, 8'h00);
    run(add_immediate_op, 8'h08, 8'h00);
    chk_flags(flg, 3'b010);
    run(and_immediate_op, 8'hf0, 8'h00);
    chk_byte(acc, 8'h10);
    run(and_immediate_op, 8'h0f, 8'h00);
    chk_byte(acc, 8'h00);
    chk_flags(flg, 3'b011);
    idle();
    $display("test literal done");
  endtask : t_literal

  task automatic t_register();
    run(add_immediate_op, 8'h3c, 8'h00);
    run(add_register_op, 8'h00, 8'hc8, DEST_FILE);
    chk_bit(file_wr_en, 1'b1);
    chk_byte({1'b0, file_wr_addr}, 8'h7f);
    chk_byte(file_wr_data, 8'h04);
    chk_byte(acc, 8'h3c);
    chk_flags(flg, 3'b110);
    idle();
    chk_bit(file_wr_en, 1'b0);
    run(and_register_op, 8'h01, 8'h0f, DEST_ACC);
    chk_byte(acc, 8'h0c);
    chk_bit(file_wr_en, 1'b0);
    run(and_register_op, 8'h02, 8'hf0, DEST_FILE);
    chk_byte(file_wr_data, 8'h00);
    chk_byte({1'b0, file_wr_addr}, 8'h7d);
    chk_flags(flg, 3'b111);
    run(add_register_op, 8'h00, 8'hf5, DEST_ACC);
    chk_byte(acc, 8'h01);
    chk_flags(flg, 3'b110);
    idle();
    $display("test register done");
  endtask : t_register

  task automatic t_bits();
    keep = flg;
    for (int b = 0; b < 8; b++) begin
      run(bit_set_op, 8'h00, 8'h00, 1'b0, 3'(b));
      chk_byte(file_wr_data, 8'h01 << b);
      run(bit_clear_op, 8'h00, 8'hff, 1'b0, 3'(b));
      chk_byte(file_wr_data, ~(8'h01 << b));
      chk_flags(flg, keep);
    end
    // port operand comes from the pins, not the latch
    run(bit_set_op, 8'h00, 8'hfe, 1'b0, 3'h0, 1'b1, 8'h40);
    chk_byte(file_wr_data, 8'h41);
    run(bit_clear_op, 8'h00, 8'h00, 1'b0, 3'h4, 1'b1, 8'hf0);
    chk_byte(file_wr_data, 8'he0);
    idle();
    $display("test bits done");
  endtask : t_bits

  task automatic t_clear();
    run(add_immediate_op, 8'h01, 8'h00);
    run(register_zero_op, 8'h00, 8'h5a);
    chk_bit(file_wr_en, 1'b1);
    chk_byte(file_wr_data, 8'h00);
    chk_flags(flg, 3'b001);
    idle();
    $display("test clear done");
  endtask : t_clear

  task automatic t_skip();
    run(skip_if_bit_one_op, 8'h00, 8'h80, 1'b0, 3'h7);
    chk_flags(flg, 3'b001);
    run(add_immediate_op, 8'h55, 8'h00);
    chk_byte(acc, 8'h02);
    chk_bit(slot_discarded, 1'b1);
    run(add_immediate_op, 8'h01, 8'h00);
    chk_byte(acc, 8'h03);
    chk_bit(slot_discarded, 1'b0);
    run(skip_if_bit_one_op, 8'h00, 8'h7f, 1'b0, 3'h7);
    run(add_immediate_op, 8'h01, 8'h00);
    chk_byte(acc, 8'h04);
    chk_bit(slot_discarded, 1'b0);
    // pending skip waits across idle cycles
    run(skip_if_bit_one_op, 8'h00, 8'h01, 1'b0, 3'h0);
    idle();
    idle();
    run(and_immediate_op, 8'h00, 8'h00);
    chk_byte(acc, 8'h04);
    chk_bit(slot_discarded, 1'b1);
    idle();
    $display("test skip done");
  endtask : t_skip

  // mid-run reset must also drop a skip that is still waiting for its slot
  task automatic t_reset();
    run(skip_if_bit_one_op, 8'h00, 8'h01, 1'b0, 3'h0);
    issue = 1'b0;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk_byte(acc, ACC_RESET);
    chk_flags(flg, {FLAG_RESET, FLAG_RESET, FLAG_RESET});
    run(add_immediate_op, 8'h21, 8'h00);
    chk_byte(acc, 8'h21);
    chk_bit(slot_discarded, 1'b0);
    idle();
    $display("test reset done");
  endtask : t_reset

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // main sequence, inputs change on falling edges
  initial begin
    rst = 1'b1;
    issue = 1'b0;
    op = add_immediate_op;
    literal = 8'h00;
    file_addr = 7'h00;
    dest = 1'b0;
    bit_sel = 3'h0;
    file_rd_data = 8'h00;
    file_is_port = 1'b0;
    pin_level = 8'h00;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_literal();
    t_register();
    t_bits();
    t_clear();
    t_skip();
    t_reset();
    finish_test();
  end

  // watchdog, far beyond the 70 or so cycles the tests need
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule : tb_lbo_datapath
